// *** hw/lbps_sync.sv ***
`timescale 1ns/1ps

// three-stage synchroniser; a bit is taken once stages two and three agree
module lbps_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] st1_reg;
  logic [WIDTH-1:0] st2_reg;
  logic [WIDTH-1:0] st3_reg;

  if (WIDTH < 1) begin : g_chk
    $error("lbps_sync: WIDTH must be at least 1");
  end

  // ==========================================================
  // synchroniser chain
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st1_reg <= RST_VAL;
      st2_reg <= RST_VAL;
      st3_reg <= RST_VAL;
    end else begin
      st1_reg <= i_async;
      st2_reg <= st1_reg;
      st3_reg <= st2_reg;
    end
  end

  // ==========================================================
  // agreement stage
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_sync <= RST_VAL;
    end else begin
      for (int b = 0; b < WIDTH; b++) begin
        if (st2_reg[b] == st3_reg[b]) begin
          o_sync[b] <= st3_reg[b];
        end
      end
    end
  end

endmodule // lbps_sync

// *** hw/lbps_top.sv ***
`timescale 1ns/1ps
`include "lbps_consts.svh"

// How it works
// - supply below lockout keeps all bias off
// - enable low keeps all bias off
// - enable high starts boost, negative pump, common voltage
// - positive pump waits for boost power good
// - enable falling disables every bias function
// - panel detect picks power-up, normal, power-down
// - normal: each shifter output follows its input
// - power-up: shifter outputs held at low rail a
// - power-down: shifter outputs forced to high rail
// - both discharge outputs share the detect result
// - up/normal: discharge a, b on low rails
// - power-down: both discharge outputs on high rail
// - power-up with detect low: reset driven low
// - normal with detect high: reset released
// - power-down with detect low: reset low again
// - discharge paths work while gate rails hold
// - over-temperature disables bias, resumes when cleared
// - reset low below reference, released above hysteresis
// - reset logic ignores the supply lockout
// - pump fault latches off until supply/enable cycle
module lbps_top #(
  parameter int LS_CHANNELS = `LBPS_LS_CHANNELS,
  parameter int FILT_CYCLES = `LBPS_FILT_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_supply_ok,
  input wire logic i_enable,
  input wire logic i_boost_pg,
  input wire logic i_over_temp,
  input wire logic i_pump_fault,
  input wire logic i_detect_above_ref,
  input wire logic i_detect_above_hyst,
  input wire logic i_gate_rails_ok,
  input wire logic [LS_CHANNELS-1:0] i_ls_in,
  output logic o_boost_en,
  output logic o_neg_pump_en,
  output logic o_pos_pump_en,
  output logic o_common_voltage_generator_en,
  output logic [LS_CHANNELS*`LBPS_RAIL_W-1:0] o_ls_rail,
  output logic [`LBPS_RAIL_W-1:0] o_discharge_out_a,
  output logic [`LBPS_RAIL_W-1:0] o_discharge_out_b,
  output logic o_panel_reset_out_n_o,
  output logic o_panel_reset_out_n_oe,
  output logic o_fault_latched,
  output logic [2:0] o_panel_phase
);

  localparam int CNT_W = (FILT_CYCLES < 2) ? 1 : $clog2(FILT_CYCLES);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(FILT_CYCLES - 1);
  localparam int NF = `LBPS_NUM_FLAGS;

  // ==========================================================
  // elaboration checks
  if (LS_CHANNELS < 1) begin : g_chk_ch
    $error("lbps_top: LS_CHANNELS must be at least 1");
  end
  if (FILT_CYCLES < 1) begin : g_chk_filt
    $error("lbps_top: FILT_CYCLES must be at least 1");
  end

  // ==========================================================
  // declarations
  logic [NF-1:0] flag_raw;
  logic [NF-1:0] flag_sync;
  logic [NF-1:0] flag_reg;
  logic [CNT_W-1:0] flt_cnt_reg [NF];
  logic [LS_CHANNELS-1:0] ls_in_sync;
  logic det_high_reg;
  logic det_high_next;
  logic bias_allowed;
  lbps_pkg::lbps_bias_t bias_reg;
  lbps_pkg::lbps_bias_t bias_next;
  lbps_pkg::lbps_panel_t panel_reg;
  lbps_pkg::lbps_panel_t panel_next;
  logic bias_starting;

  // ==========================================================
  // helpers
  function automatic logic [`LBPS_RAIL_W-1:0] rail_gate(
    input logic rails_ok,
    input lbps_pkg::lbps_rail_t rail
  );
    // stages stay idle while the gate rails are collapsed
    rail_gate = rails_ok ? rail : lbps_pkg::LBPS_RAIL_NONE;
  endfunction

  function automatic logic is_on(input lbps_pkg::lbps_bias_t st);
    is_on = (st == lbps_pkg::LBPS_BIAS_START) || (st == lbps_pkg::LBPS_BIAS_RUN);
  endfunction

  // ==========================================================
  // input synchronisers
  assign flag_raw[`LBPS_F_SUPPLY] = i_supply_ok;
  assign flag_raw[`LBPS_F_ENABLE] = i_enable;
  assign flag_raw[`LBPS_F_BOOST_PG] = i_boost_pg;
  assign flag_raw[`LBPS_F_OVER_TEMP] = i_over_temp;
  assign flag_raw[`LBPS_F_CP_FAULT] = i_pump_fault;
  assign flag_raw[`LBPS_F_DET_REF] = i_detect_above_ref;
  assign flag_raw[`LBPS_F_DET_HYST] = i_detect_above_hyst;
  assign flag_raw[`LBPS_F_RAILS_OK] = i_gate_rails_ok;

  lbps_sync #(
    .WIDTH(NF),
    .RST_VAL(`LBPS_FLAGS_RST)
  ) u_flag_sync (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_async(flag_raw),
    .o_sync(flag_sync)
  );

  lbps_sync #(
    .WIDTH(LS_CHANNELS),
    .RST_VAL('0)
  ) u_ls_sync (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_async(i_ls_in),
    .o_sync(ls_in_sync)
  );

  // ==========================================================
  // glitch filters: a flag changes after FILT_CYCLES steady cycles
  for (genvar f = 0; f < NF; f++) begin : g_flt
    always_ff @(posedge i_mclk) begin
      if (i_rst) begin
        flag_reg[f] <= 1'b0;
        flt_cnt_reg[f] <= '0;
      end else if (flag_sync[f] == flag_reg[f]) begin
        flt_cnt_reg[f] <= '0;
      end else if (flt_cnt_reg[f] == CNT_LAST) begin
        flag_reg[f] <= flag_sync[f];
        flt_cnt_reg[f] <= '0;
      end else begin
        flt_cnt_reg[f] <= flt_cnt_reg[f] + CNT_W'(1);
      end
    end
  end

  // ==========================================================
  // panel detect with hysteresis
  always_comb begin
    det_high_next = det_high_reg;
    if (flag_reg[`LBPS_F_DET_HYST]) begin
      det_high_next = 1'b1;
    end else if (!flag_reg[`LBPS_F_DET_REF]) begin
      det_high_next = 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      det_high_reg <= 1'b0;
    end else begin
      det_high_reg <= det_high_next;
    end
  end

  // ==========================================================
  // bias sequencer
  // lockout, enable low and over-temperature force start and run back to off; lockout and enable low also clear the fault
  assign bias_allowed = flag_reg[`LBPS_F_SUPPLY]
      && flag_reg[`LBPS_F_ENABLE]
      && !flag_reg[`LBPS_F_OVER_TEMP];

  always_comb begin
    bias_next = bias_reg;
    unique case (bias_reg)
      lbps_pkg::LBPS_BIAS_OFF: begin
        if (bias_allowed) begin
          bias_next = lbps_pkg::LBPS_BIAS_START;
        end
      end
      lbps_pkg::LBPS_BIAS_START: begin
        // a fault that coincides with a shutdown still latches
        if (flag_reg[`LBPS_F_CP_FAULT]) begin
          bias_next = lbps_pkg::LBPS_BIAS_FAULT;
        end else if (!bias_allowed) begin
          bias_next = lbps_pkg::LBPS_BIAS_OFF;
        end else if (flag_reg[`LBPS_F_BOOST_PG]) begin
          bias_next = lbps_pkg::LBPS_BIAS_RUN;
        end
      end
      lbps_pkg::LBPS_BIAS_RUN: begin
        if (flag_reg[`LBPS_F_CP_FAULT]) begin
          bias_next = lbps_pkg::LBPS_BIAS_FAULT;
        end else if (!bias_allowed) begin
          bias_next = lbps_pkg::LBPS_BIAS_OFF;
        end
      end
      lbps_pkg::LBPS_BIAS_FAULT: begin
        // only a supply or enable cycle clears the latch
        if (!flag_reg[`LBPS_F_SUPPLY] || !flag_reg[`LBPS_F_ENABLE]) begin
          bias_next = lbps_pkg::LBPS_BIAS_OFF;
        end
      end
      default: begin
        bias_next = lbps_pkg::LBPS_BIAS_OFF;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      bias_reg <= lbps_pkg::LBPS_BIAS_OFF;
    end else begin
      bias_reg <= bias_next;
    end
  end

  assign bias_starting = (bias_reg == lbps_pkg::LBPS_BIAS_OFF)
      && (bias_next == lbps_pkg::LBPS_BIAS_START);

  // ==========================================================
  // bias enables
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_boost_en <= 1'b0;
      o_neg_pump_en <= 1'b0;
      o_common_voltage_generator_en <= 1'b0;
      o_pos_pump_en <= 1'b0;
      o_fault_latched <= 1'b0;
    end else begin
      o_boost_en <= is_on(bias_next);
      o_neg_pump_en <= is_on(bias_next);
      o_common_voltage_generator_en <= is_on(bias_next);
      o_pos_pump_en <= (bias_next == lbps_pkg::LBPS_BIAS_RUN);
      o_fault_latched <= (bias_next == lbps_pkg::LBPS_BIAS_FAULT);
    end
  end

  // ==========================================================
  // panel phase: the detect comparison moves between power-up, normal and power-down;
  // power-down returns to power-up when the bias sequencer starts
  always_comb begin
    panel_next = panel_reg;
    unique case (panel_reg)
      lbps_pkg::LBPS_PNL_UP: begin
        if (det_high_next) begin
          panel_next = lbps_pkg::LBPS_PNL_NORMAL;
        end
      end
      lbps_pkg::LBPS_PNL_NORMAL: begin
        if (!det_high_next) begin
          panel_next = lbps_pkg::LBPS_PNL_DOWN;
        end
      end
      lbps_pkg::LBPS_PNL_DOWN: begin
        if (det_high_next) begin
          panel_next = lbps_pkg::LBPS_PNL_NORMAL;
        end else if (bias_starting) begin
          panel_next = lbps_pkg::LBPS_PNL_UP;
        end
      end
      default: begin
        panel_next = lbps_pkg::LBPS_PNL_UP;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      panel_reg <= lbps_pkg::LBPS_PNL_UP;
    end else begin
      panel_reg <= panel_next;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_panel_phase <= lbps_pkg::LBPS_PNL_UP;
    end else begin
      o_panel_phase <= panel_next;
    end
  end

  // ==========================================================
  // level shifter rails
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_ls_rail <= '0;
    end else begin
      for (int c = 0; c < LS_CHANNELS; c++) begin
        unique case (panel_next)
          lbps_pkg::LBPS_PNL_NORMAL: begin
            o_ls_rail[c*`LBPS_RAIL_W +: `LBPS_RAIL_W] <= rail_gate(
                flag_reg[`LBPS_F_RAILS_OK],
                ls_in_sync[c] ? lbps_pkg::LBPS_RAIL_HIGH
                              : lbps_pkg::LBPS_RAIL_LOW_A);
          end
          lbps_pkg::LBPS_PNL_DOWN: begin
            o_ls_rail[c*`LBPS_RAIL_W +: `LBPS_RAIL_W] <= rail_gate(
                flag_reg[`LBPS_F_RAILS_OK], lbps_pkg::LBPS_RAIL_HIGH);
          end
          default: begin
            o_ls_rail[c*`LBPS_RAIL_W +: `LBPS_RAIL_W] <= rail_gate(
                flag_reg[`LBPS_F_RAILS_OK], lbps_pkg::LBPS_RAIL_LOW_A);
          end
        endcase
      end
    end
  end

  // ==========================================================
  // panel discharge: one shared phase drives both outputs
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_discharge_out_a <= lbps_pkg::LBPS_RAIL_NONE;
      o_discharge_out_b <= lbps_pkg::LBPS_RAIL_NONE;
    end else if (panel_next == lbps_pkg::LBPS_PNL_DOWN) begin
      o_discharge_out_a <= rail_gate(flag_reg[`LBPS_F_RAILS_OK],
                                     lbps_pkg::LBPS_RAIL_HIGH);
      o_discharge_out_b <= rail_gate(flag_reg[`LBPS_F_RAILS_OK],
                                     lbps_pkg::LBPS_RAIL_HIGH);
    end else begin
      o_discharge_out_a <= rail_gate(flag_reg[`LBPS_F_RAILS_OK],
                                     lbps_pkg::LBPS_RAIL_LOW_A);
      o_discharge_out_b <= rail_gate(flag_reg[`LBPS_F_RAILS_OK],
                                     lbps_pkg::LBPS_RAIL_LOW_B);
    end
  end

  // ==========================================================
  // open-drain panel reset; no dependence on supply or bias state
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_panel_reset_out_n_o <= 1'b0;
      o_panel_reset_out_n_oe <= 1'b1;
    end else begin
      o_panel_reset_out_n_o <= 1'b0;
      // low in power-up and power-down, released in normal
      o_panel_reset_out_n_oe <= (panel_next != lbps_pkg::LBPS_PNL_NORMAL);
    end
  end

endmodule // lbps_top

// *** shared/lbps_consts.svh ***
`ifndef LBPS_CONSTS_SVH
`define LBPS_CONSTS_SVH

// ==========================================================
// clock and filter timing
`define LBPS_CLK_PERIOD_NS 10
`define LBPS_FILT_NS 50
`define LBPS_FILT_CYC ((`LBPS_FILT_NS + `LBPS_CLK_PERIOD_NS - 1) / `LBPS_CLK_PERIOD_NS)

// ==========================================================
// positions of the filtered status flags
`define LBPS_NUM_FLAGS 8
`define LBPS_F_SUPPLY 0
`define LBPS_F_ENABLE 1
`define LBPS_F_BOOST_PG 2
`define LBPS_F_OVER_TEMP 3
`define LBPS_F_CP_FAULT 4
`define LBPS_F_DET_REF 5
`define LBPS_F_DET_HYST 6
`define LBPS_F_RAILS_OK 7

// ==========================================================
// reset values of the flag synchronisers (everything inactive)
`define LBPS_FLAGS_RST 8'h00

// ==========================================================
// level shifter geometry
`define LBPS_LS_CHANNELS 8
`define LBPS_RAIL_W 2

`endif

// *** shared/lbps_pkg.sv ***
package lbps_pkg;

  // ==========================================================
  // rail selection code for one high-level output stage
  typedef enum logic [1:0] {
    LBPS_RAIL_NONE = 2'h0,
    LBPS_RAIL_LOW_A = 2'h1,
    LBPS_RAIL_LOW_B = 2'h2,
    LBPS_RAIL_HIGH = 2'h3
  } lbps_rail_t;

  // ==========================================================
  // bias sequencer states
  typedef enum logic [3:0] {
    LBPS_BIAS_OFF = 4'h1,
    LBPS_BIAS_START = 4'h2,
    LBPS_BIAS_RUN = 4'h4,
    LBPS_BIAS_FAULT = 4'h8
  } lbps_bias_t;

  // ==========================================================
  // panel phase states
  typedef enum logic [2:0] {
    LBPS_PNL_UP = 3'h1,
    LBPS_PNL_NORMAL = 3'h2,
    LBPS_PNL_DOWN = 3'h4
  } lbps_panel_t;

endpackage

// *** tb/lbps_tb_top.sv ***
`timescale 1ns/1ps
`include "lbps_consts.svh"

module lbps_tb_top;
  localparam int N = `LBPS_LS_CHANNELS;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic supply_ok = 1'b1, enable = 1'b0, boost_pg = 1'b0, over_temp = 1'b0;
  logic pump_fault = 1'b0, above_ref = 1'b0, above_hyst = 1'b0, rails_ok = 1'b1;
  logic [N-1:0] pattern = '0;
  logic [N-1:0] ls_in;
  logic boost_en, neg_en, pos_en, com_en, rst_o, rst_oe, fault, reset_line;
  logic [2*N-1:0] ls_rail;
  logic [1:0] dis_a, dis_b;
  logic [2:0] phase;
  logic [31:0] obs, last_obs;
  logic [31:0] notes[$];
  int n_mismatch = 0, n_tests = 0, seed = 32'h473B861E, stable_cnt = 0;
  int e_bias = 0;
  logic [2:0] e_phase = 3'h1;
  logic e_fault = 1'b0, armed = 1'b0;

  always #5 i_mclk = ~i_mclk;

  lbps_top #(.LS_CHANNELS(N), .FILT_CYCLES(1)) i_dut (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_supply_ok(supply_ok), .i_enable(enable),
    .i_boost_pg(boost_pg), .i_over_temp(over_temp), .i_pump_fault(pump_fault),
    .i_detect_above_ref(above_ref), .i_detect_above_hyst(above_hyst),
    .i_gate_rails_ok(rails_ok), .i_ls_in(ls_in), .o_boost_en(boost_en),
    .o_neg_pump_en(neg_en), .o_pos_pump_en(pos_en), .o_common_voltage_generator_en(com_en),
    .o_ls_rail(ls_rail), .o_discharge_out_a(dis_a), .o_discharge_out_b(dis_b),
    .o_panel_reset_out_n_o(rst_o), .o_panel_reset_out_n_oe(rst_oe),
    .o_fault_latched(fault), .o_panel_phase(phase));

  lbps_tcon_model #(.N(N)) i_tcon (.i_mclk(i_mclk), .i_oe(rst_oe), .i_o(rst_o),
    .i_pattern(pattern), .o_reset_line(reset_line), .o_ls_in(ls_in));

  assign obs = {rst_o, boost_en, neg_en, com_en, pos_en, fault, phase, rst_oe, reset_line,
    dis_a, dis_b, ls_rail};

  // =====================================
  // expected outputs from the current stimulus state
  function automatic logic [31:0] expect_now();
    logic [2*N-1:0] r;
    logic [1:0] a, b;
    logic [3:0] en;
    en = (e_bias == 2) ? 4'hF : (e_bias == 1) ? 4'hE : 4'h0;
    for (int c = 0; c < N; c++) begin
      r[2*c+:2] = (e_phase == 3'h4 || (e_phase == 3'h2 && pattern[c])) ? 2'h3 : 2'h1;
    end
    a = (e_phase == 3'h4) ? 2'h3 : 2'h1;
    b = (e_phase == 3'h4) ? 2'h3 : 2'h2;
    if (!rails_ok) begin
      r = '0;
      a = 2'h0;
      b = 2'h0;
    end
    return {1'b0, en, e_fault, e_phase, e_phase != 3'h2, e_phase == 3'h2, a, b, r};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    if (notes.size() != 0) begin
      n_mismatch++;
      $display("MISMATCH at %0t: %0d results never appeared", $time, notes.size());
    end
    $display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // =====================================
  // a result is a new output state that then stays put for 15 cycles
  always @(negedge i_mclk) begin : watch
    logic [31:0] nt;
    if (obs !== last_obs) begin
      last_obs = obs;
      stable_cnt = 0;
      armed = !i_rst;
    end else if (armed && stable_cnt == 14) begin
      armed = 1'b0;
      if (notes.size() == 0) begin
        n_mismatch++;
        $display("MISMATCH at %0t: unexpected output change", $time);
      end else begin
        nt = notes.pop_front();
        check(32'(obs[30:25]), 32'(nt[30:25]));
        check(32'(obs[24:22]), 32'(nt[24:22]));
        check(32'(obs[21:20]), 32'(nt[21:20]));
        check(32'(obs[19:16]), 32'(nt[19:16]));
        check(32'(obs[15:0]), 32'(nt[15:0]));
      end
    end else begin
      stable_cnt++;
    end
  end

  // inputs already set at this falling edge; note the outcome and let it settle
  task automatic step(input int bias, input logic [2:0] ph, input logic flt, input logic note);
    e_bias = bias;
    e_phase = ph;
    e_fault = flt;
    if (note) begin
      notes.push_back(expect_now());
    end
    repeat (30) @(negedge i_mclk);
  endtask

  initial begin
    repeat (8) @(negedge i_mclk);
    i_rst = 1'b0;
    step(0, 3'h1, 0, 1);
    enable = 1'b1;
    step(1, 3'h1, 0, 1);
    boost_pg = 1'b1;
    step(2, 3'h1, 0, 1);
    above_ref = 1'b1;
    step(2, 3'h1, 0, 0);
    above_hyst = 1'b1;
    step(2, 3'h2, 0, 1);
    repeat (3) begin
      pattern = pattern ^ (N'($random(seed)) | N'(1));
      step(2, 3'h2, 0, 1);
    end
    above_hyst = 1'b0;
    step(2, 3'h2, 0, 0);
    above_ref = 1'b0;
    step(2, 3'h4, 0, 1);
    above_ref = 1'b1;
    above_hyst = 1'b1;
    step(2, 3'h2, 0, 1);
    over_temp = 1'b1;
    step(0, 3'h2, 0, 1);
    over_temp = 1'b0;
    step(2, 3'h2, 0, 1);
    pump_fault = 1'b1;
    step(0, 3'h2, 1, 1);
    pump_fault = 1'b0;
    step(0, 3'h2, 1, 0);
    enable = 1'b0;
    step(0, 3'h2, 0, 1);
    enable = 1'b1;
    step(2, 3'h2, 0, 1);
    supply_ok = 1'b0;
    step(0, 3'h2, 0, 1);
    above_ref = 1'b0;
    above_hyst = 1'b0;
    step(0, 3'h4, 0, 1);
    rails_ok = 1'b0;
    step(0, 3'h4, 0, 1);
    rails_ok = 1'b1;
    step(0, 3'h4, 0, 1);
    supply_ok = 1'b1;
    step(2, 3'h1, 0, 1);
    final_report();
  end

  initial begin
    repeat (1500) @(posedge i_mclk);
    n_mismatch++;
    $display("MISMATCH at %0t: run timed out", $time);
    final_report();
  end
endmodule // lbps_tb_top

// *** tb/lbps_tcon_model.sv ***
`timescale 1ns/1ps

// =====================================
// timing controller on the panel side: resolves the open-drain reset line and
// feeds the shifter inputs; while held in reset its shifter inputs toggle every cycle
module lbps_tcon_model #(
  parameter int N = 8
) (
  input wire logic i_mclk,
  input wire logic i_oe,
  input wire logic i_o,
  input wire logic [N-1:0] i_pattern,
  output logic o_reset_line,
  output logic [N-1:0] o_ls_in
);
  // pull-up on the line when nobody drives it
  assign o_reset_line = i_oe ? i_o : 1'b1;
  initial o_ls_in = '0;
  always @(negedge i_mclk) begin
    o_ls_in <= o_reset_line ? i_pattern : ~o_ls_in;
  end
endmodule // lbps_tcon_model

// *** tb/lbps_top_sva.sv ***
`timescale 1ns/1ps
`include "lbps_consts.svh"

module lbps_top_sva #(
  parameter int LS_CHANNELS = `LBPS_LS_CHANNELS,
  parameter int FILT_CYCLES = `LBPS_FILT_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_supply_ok,
  input wire logic i_enable,
  input wire logic i_boost_pg,
  input wire logic i_over_temp,
  input wire logic i_pump_fault,
  input wire logic i_detect_above_ref,
  input wire logic i_detect_above_hyst,
  input wire logic i_gate_rails_ok,
  input wire logic [LS_CHANNELS-1:0] i_ls_in,
  input wire logic o_boost_en,
  input wire logic o_neg_pump_en,
  input wire logic o_pos_pump_en,
  input wire logic o_common_voltage_generator_en,
  input wire logic [LS_CHANNELS*`LBPS_RAIL_W-1:0] o_ls_rail,
  input wire logic [`LBPS_RAIL_W-1:0] o_discharge_out_a,
  input wire logic [`LBPS_RAIL_W-1:0] o_discharge_out_b,
  input wire logic o_panel_reset_out_n_o,
  input wire logic o_panel_reset_out_n_oe,
  input wire logic o_fault_latched,
  input wire logic [2:0] o_panel_phase
);
  // =====================================
  // cycles each input level has held, for the filtered path latency
  localparam int LAT = FILT_CYCLES + 8;
  logic [6:0] cnt_reg [6];
  logic [5:0] cond;
  logic any_on;
  assign cond = {i_gate_rails_ok, !i_detect_above_ref, i_detect_above_hyst, i_over_temp,
    !i_enable, !i_supply_ok};
  assign any_on = o_boost_en | o_neg_pump_en | o_pos_pump_en | o_common_voltage_generator_en;
  always_ff @(posedge i_mclk) begin
    for (int k = 0; k < 6; k++) begin
      if (i_rst || !cond[k]) begin
        cnt_reg[k] <= 7'h00;
      end else if (cnt_reg[k] != 7'h7F) begin
        cnt_reg[k] <= cnt_reg[k] + 7'h01;
      end
    end
  end

  // =====================================
  // assertions
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  sequence s_boost_on;
    $rose(o_boost_en);
  endsequence
  sequence s_pos_on;
    $rose(o_pos_pump_en);
  endsequence
  start_order_a: assert property (s_boost_on |-> o_neg_pump_en &&
    o_common_voltage_generator_en && !o_pos_pump_en) else $error("start order wrong");
  pos_after_pg_a: assert property (s_pos_on |-> $past(i_boost_pg, 3) && o_boost_en)
    else $error("positive pump on without power good");
  supply_off_a: assert property (cnt_reg[0] >= LAT |-> !any_on)
    else $error("bias on with supply low");
  enable_off_a: assert property (cnt_reg[1] >= LAT |-> !any_on)
    else $error("bias on with enable low");
  temp_off_a: assert property (cnt_reg[2] >= LAT |-> !any_on)
    else $error("bias on while over temperature");
  reset_release_a: assert property (cnt_reg[3] >= LAT |-> !o_panel_reset_out_n_oe)
    else $error("reset not released");
  reset_pull_a: assert property (cnt_reg[4] >= LAT |->
    o_panel_reset_out_n_oe && !o_panel_reset_out_n_o) else $error("reset not pulled low");
  down_rails_a: assert property (o_panel_phase == 3'h4 && $stable(o_panel_phase) &&
    cnt_reg[5] >= LAT |-> o_ls_rail == {LS_CHANNELS{2'h3}} && o_discharge_out_a == 2'h3 &&
    o_discharge_out_b == 2'h3) else $error("power-down rails wrong");
  up_rails_a: assert property (o_panel_phase == 3'h1 && $stable(o_panel_phase) &&
    cnt_reg[5] >= LAT |-> o_ls_rail == {LS_CHANNELS{2'h1}} && o_discharge_out_a == 2'h1 &&
    o_discharge_out_b == 2'h2) else $error("power-up rails wrong");
  fault_off_a: assert property (o_fault_latched |-> !any_on)
    else $error("bias on while fault latched");
  phase_onehot_a: assert property ($onehot(o_panel_phase))
    else $error("panel phase not one-hot");
endmodule // lbps_top_sva

bind lbps_top lbps_top_sva #(.LS_CHANNELS(LS_CHANNELS), .FILT_CYCLES(FILT_CYCLES)) i_sva (
  .i_mclk, .i_rst, .i_supply_ok, .i_enable, .i_boost_pg, .i_over_temp, .i_pump_fault,
  .i_detect_above_ref, .i_detect_above_hyst, .i_gate_rails_ok, .i_ls_in, .o_boost_en,
  .o_neg_pump_en, .o_pos_pump_en, .o_common_voltage_generator_en, .o_ls_rail,
  .o_discharge_out_a, .o_discharge_out_b, .o_panel_reset_out_n_o, .o_panel_reset_out_n_oe,
  .o_fault_latched, .o_panel_phase);
